// File: design/eea_access_ctrl.sv
// data eeprom access controller: registers, unlock, timing, stall
// Notes on behaviour
// - unused address-high bits 7:3 and control bits 7:4 read as zero
// - eleven-bit address picks one byte linearly from zero
// - address bit 10 reaches the array only on the large variant
// - data byte feeds writes and receives read results
// - ready interrupt is a level while enabled, global enable set, not busy
// - write starts only if strobe set within four cycles of unlock
// - strobe without unlock is ignored
// - hardware clears unlock four cycles after software sets it
// - write strobe stays set while programming, cleared when time elapses
// - write start without the read strobe stalls the processor two cycles
// - read strobe loads data at once and stalls four cycles
// - during a write reads are refused and address writes ignored
// - write lasts 27072 ticks of the rc oscillator
// - write survives power-down; oscillator stays requested afterwards
// - a running write completes through a system reset
`timescale 1ns/1ns
module eea_access_ctrl
  import eea_pkg::*;
#(
  parameter bit LARGE_ARRAY    = 1'b1,
  parameter int WRITE_RC_TICKS = EEA_WRITE_RC_TICKS
) (
  // clock and resets
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  POR,
  input  wire logic                  CE,
  // processor i/o port
  input  wire logic [5:0]            IO_ADDR,
  input  wire logic                  IO_WE,
  input  wire logic                  IO_RE,
  input  wire logic [7:0]            IO_WDATA,
  output logic      [7:0]            IO_RDATA,
  output logic                       CPU_HALT,
  // processor status
  input  wire logic                  GLOBAL_IE,
  input  wire logic                  SLEEP_PWRDN,
  output logic                       READY_IRQ,
  // oscillator
  input  wire logic                  RC_TICK,
  output logic                       RC_OSC_HOLD,
  // eeprom array
  output logic      [EEA_ADDR_W-1:0] ARR_ADDR,
  output logic      [7:0]            ARR_WDATA,
  output logic                       ARR_WE,
  output logic                       ARR_PROG,
  input  wire logic [7:0]            ARR_RDATA
);
  localparam logic [EEA_TMR_W-1:0] UNLOCK_LOAD = EEA_TMR_W'(EEA_UNLOCK_CYCLES);
  localparam logic [EEA_TMR_W-1:0] WR_HALT     = EEA_TMR_W'(EEA_WR_STALL);
  localparam logic [EEA_TMR_W-1:0] RD_HALT     = EEA_TMR_W'(EEA_RD_STALL);
  localparam logic [EEA_WR_TMR_W-1:0] WR_LOAD  = EEA_WR_TMR_W'(WRITE_RC_TICKS);

  logic [7:0]               addr_low;
  logic [EEA_ADDR_HI_W-1:0] addr_high;
  logic [7:0]               data_byte;
  logic                     ready_interrupt_enable;
  logic                     read_strobe;
  logic                     unlock_busy;
  logic                     write_strobe_busy;
  logic                     halt_busy;
  logic                     rc_sync;
  logic                     rc_prev;
  logic                     rc_edge;
  logic                     wr_ctl;
  logic                     start_write;
  logic                     start_read;
  logic [EEA_TMR_W-1:0]     halt_load;

  // decoded accesses
  assign wr_ctl      = CE && IO_WE && (IO_ADDR == EEA_OFS_CONTROL);
  assign start_write = wr_ctl && IO_WDATA[EEA_BIT_WRITE] && unlock_busy
                       && !write_strobe_busy;
  assign start_read  = wr_ctl && IO_WDATA[EEA_BIT_READ] && !write_strobe_busy;
  assign halt_load   = start_read ? RD_HALT : WR_HALT;

  eea_cycle_timer #(.W(EEA_TMR_W)) u_unlock (
    .clk      (CLK_SYS),
    .clr      (RST),
    .ce       (CE),
    .load     (wr_ctl && IO_WDATA[EEA_BIT_UNLOCK]),
    .load_val (UNLOCK_LOAD),
    .step     (1'b1),
    .busy     (unlock_busy),
    .done     ()
  );

  eea_cycle_timer #(.W(EEA_TMR_W)) u_halt (
    .clk      (CLK_SYS),
    .clr      (RST),
    .ce       (CE),
    .load     (start_write || start_read),
    .load_val (halt_load),
    .step     (1'b1),
    .busy     (halt_busy),
    .done     ()
  );
  assign CPU_HALT = halt_busy;

  // oscillator tick synchroniser
  eea_sync2 u_rc_sync (
    .clk  (CLK_SYS),
    .rst  (POR),
    .ce   (CE),
    .din  (RC_TICK),
    .dout (rc_sync)
  );

  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      rc_prev <= 1'b0;
    end else if (CE) begin
      rc_prev <= rc_sync;
    end
  end
  assign rc_edge = rc_sync && !rc_prev;

  // write timer, cleared only by power-on
  eea_cycle_timer #(.W(EEA_WR_TMR_W)) u_write (
    .clk      (CLK_SYS),
    .clr      (POR),
    .ce       (CE),
    .load     (start_write),
    .load_val (WR_LOAD),
    .step     (rc_edge),
    .busy     (write_strobe_busy),
    .done     ()
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      addr_low  <= EEA_RST_BYTE;
      addr_high <= EEA_RST_HI;
    end else if (CE && IO_WE && !write_strobe_busy) begin
      if (IO_ADDR == EEA_OFS_ADDR_LOW) begin
        addr_low <= IO_WDATA;
      end
      if (IO_ADDR == EEA_OFS_ADDR_HIGH) begin
        addr_high <= IO_WDATA[EEA_ADDR_HI_W-1:0];
      end
    end
  end

  // data byte, loaded by a read
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      data_byte <= EEA_RST_BYTE;
    end else if (CE) begin
      if (start_read) begin
        data_byte <= ARR_RDATA;
      end else if (IO_WE && (IO_ADDR == EEA_OFS_DATA)) begin
        data_byte <= IO_WDATA;
      end
    end
  end

  // control bits
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ready_interrupt_enable <= 1'b0;
      read_strobe            <= 1'b0;
    end else if (CE) begin
      if (wr_ctl) begin
        ready_interrupt_enable <= IO_WDATA[EEA_BIT_RIE];
      end
      read_strobe <= start_read;
    end
  end

  always_comb begin
    ARR_ADDR = {addr_high, addr_low};
    if (!LARGE_ARRAY) begin
      ARR_ADDR[EEA_ADDR_TOP] = 1'b0;
    end
  end

  // write data captured at start
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      ARR_WDATA <= EEA_RST_BYTE;
      ARR_WE    <= 1'b0;
    end else if (CE) begin
      ARR_WE <= start_write;
      if (start_write) begin
        ARR_WDATA <= data_byte;
      end
    end
  end
  assign ARR_PROG = write_strobe_busy;

  assign READY_IRQ = ready_interrupt_enable && GLOBAL_IE && !write_strobe_busy;

  // oscillator kept running once a write met power-down
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      RC_OSC_HOLD <= 1'b0;
    end else if (CE) begin
      RC_OSC_HOLD <= SLEEP_PWRDN && (RC_OSC_HOLD || write_strobe_busy);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IO_RDATA <= EEA_RST_BYTE;
    end else if (CE && IO_RE) begin
      case (IO_ADDR)
        EEA_OFS_ADDR_LOW:  IO_RDATA <= addr_low;
        EEA_OFS_ADDR_HIGH: IO_RDATA <= {5'h00, addr_high};
        EEA_OFS_DATA:      IO_RDATA <= data_byte;
        EEA_OFS_CONTROL:   IO_RDATA <= {4'h0, ready_interrupt_enable, unlock_busy,
                                        write_strobe_busy, read_strobe};
        default:           IO_RDATA <= EEA_RST_BYTE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST || POR || !CE);

  AST_UNLOCK_CLOSES: assert property (
    (wr_ctl && IO_WDATA[EEA_BIT_UNLOCK]) |=> (unlock_busy [*4] ##1 !unlock_busy)
                                              or ##[0:3] (wr_ctl && IO_WDATA[EEA_BIT_UNLOCK]))
    else $error("unlock window not four cycles");
  AST_NO_WRITE_LOCKED: assert property (
    (wr_ctl && IO_WDATA[EEA_BIT_WRITE] && !unlock_busy && !write_strobe_busy)
      |=> !ARR_WE && !write_strobe_busy)
    else $error("write started without unlock");
  AST_WRITE_STARTS: assert property (
    (wr_ctl && IO_WDATA[EEA_BIT_WRITE] && unlock_busy && !write_strobe_busy)
      |=> ARR_WE && write_strobe_busy && ARR_WDATA == $past(data_byte))
    else $error("unlocked write did not start");
  AST_WRITE_HALT: assert property (
    start_write && !start_read |=> CPU_HALT [*2] ##1 !CPU_HALT)
    else $error("write stall not two cycles");
  AST_READ_HALT: assert property (
    start_read |=> CPU_HALT [*4] ##1 !CPU_HALT)
    else $error("read stall not four cycles");
  AST_READ_DATA: assert property (
    start_read |=> data_byte == $past(ARR_RDATA) && read_strobe)
    else $error("read data not loaded");
  AST_READ_SELF_CLEAR: assert property (
    read_strobe |=> !read_strobe || $past(start_read))
    else $error("read strobe stuck");
  AST_BUSY_BLOCKS: assert property (
    write_strobe_busy && !rc_edge |=> $stable(ARR_ADDR) && $stable(data_byte)
                                      || $past(IO_WE && IO_ADDR == EEA_OFS_DATA))
    else $error("address or data changed during write");
  AST_IRQ_LEVEL: assert property (
    start_write |=> !READY_IRQ)
    else $error("ready interrupt during write");
  AST_IRQ_AFTER_WRITE: assert property (
    $fell(ARR_PROG) && ready_interrupt_enable && GLOBAL_IE |-> READY_IRQ)
    else $error("ready interrupt missing after write");
  AST_RESERVED_ZERO: assert property (
    $past(CE && !RST && IO_RE && IO_ADDR == EEA_OFS_CONTROL) |-> IO_RDATA[7:4] == 4'h0)
    else $error("reserved control bits nonzero");
  AST_CTL_BUSY: assert property (
    $past(CE && !RST && IO_RE && IO_ADDR == EEA_OFS_CONTROL)
      |-> IO_RDATA[EEA_BIT_WRITE] == $past(ARR_PROG))
    else $error("busy bit read back wrong");
  AST_READ_REFUSED: assert property (
    wr_ctl && IO_WDATA[EEA_BIT_READ] && write_strobe_busy |=> !read_strobe)
    else $error("read performed during write");
  AST_ADDR_FROZEN: assert property (
    write_strobe_busy && IO_WE
      && (IO_ADDR == EEA_OFS_ADDR_LOW || IO_ADDR == EEA_OFS_ADDR_HIGH) |=> $stable(ARR_ADDR))
    else $error("address changed during write");
  AST_WRITE_ONE_PULSE: assert property (
    ARR_WE |=> !ARR_WE)
    else $error("array write strobe longer than one cycle");
  AST_HOLD_AFTER_PWRDN: assert property (
    write_strobe_busy && SLEEP_PWRDN ##1 SLEEP_PWRDN |-> RC_OSC_HOLD)
    else $error("oscillator hold not set");
  AST_OSC_RELEASE: assert property (
    !SLEEP_PWRDN |=> !RC_OSC_HOLD)
    else $error("oscillator hold outside power-down");
  AST_RESET_KEEPS_WRITE: assert property (
    @(posedge CLK_SYS) disable iff (POR || !CE)
    RST && write_strobe_busy && !rc_edge |=> write_strobe_busy)
    else $error("reset aborted a running write");

  COV_WRITE: cover property (start_write ##[1:20] ARR_WE);
  COV_READ: cover property (start_read ##5 !CPU_HALT);
  COV_LOCKED: cover property (wr_ctl && IO_WDATA[EEA_BIT_WRITE] && !unlock_busy);
  COV_IRQ: cover property ($rose(READY_IRQ));
  COV_RESET_IN_WRITE: cover property (@(posedge CLK_SYS) disable iff (POR) RST && write_strobe_busy);
endmodule // eea_access_ctrl

// File: design/eea_cycle_timer.sv
// loadable down counter with busy and done
`timescale 1ns/1ns
module eea_cycle_timer #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         clr,
  input  wire logic         ce,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         step,
  // status
  output logic              busy,
  output logic              done
);
  logic [W-1:0] count;

  always_ff @(posedge clk) begin
    if (clr) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= load_val;
      end else if (step && busy) begin
        count <= count - W'(1);
      end
    end
  end

  assign busy = (count != '0);
  assign done = ce && step && !load && (count == W'(1));
endmodule // eea_cycle_timer

// File: design/eea_pkg.sv
// constants shared by the data eeprom access controller
package eea_pkg;
  // i/o space offsets
  localparam logic [5:0] EEA_OFS_CONTROL   = 6'h1F;
  localparam logic [5:0] EEA_OFS_DATA      = 6'h20;
  localparam logic [5:0] EEA_OFS_ADDR_LOW  = 6'h21;
  localparam logic [5:0] EEA_OFS_ADDR_HIGH = 6'h22;
  // control field positions
  localparam int EEA_BIT_READ   = 0;
  localparam int EEA_BIT_WRITE  = 1;
  localparam int EEA_BIT_UNLOCK = 2;
  localparam int EEA_BIT_RIE    = 3;
  // address layout
  localparam int EEA_ADDR_W     = 11;
  localparam int EEA_ADDR_HI_W  = 3;
  localparam int EEA_ADDR_TOP   = 10;
  // reset values
  localparam logic [7:0] EEA_RST_BYTE = 8'h00;
  localparam logic [2:0] EEA_RST_HI   = 3'h0;
  // timing, in cpu clock cycles or oscillator ticks
  localparam int EEA_TMR_W          = 3;
  localparam int EEA_UNLOCK_CYCLES  = 4;
  localparam int EEA_WR_STALL       = 2;
  localparam int EEA_RD_STALL       = 4;
  localparam int EEA_WR_TMR_W       = 15;
  localparam int EEA_WRITE_RC_TICKS = 27072;
endpackage

// File: design/eea_sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module eea_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // eea_sync2

// File: verif/eea_array_model.sv
// eeprom array and rc oscillator model
`timescale 1ns/1ns
module eea_array_model (
  // clock
  input  wire logic        clk,
  // array side
  input  wire logic [10:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_we,
  output logic      [7:0]  arr_rdata,
  // oscillator
  output logic             rc_tick
);
  logic [7:0] mem [0:2047];
  initial begin
    rc_tick = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    #7;
    forever #80 rc_tick = ~rc_tick;
  end
  always @(posedge clk) if (arr_we) mem[arr_addr] <= arr_wdata;
  assign arr_rdata = mem[arr_addr];
endmodule // eea_array_model

// File: verif/test_eeprom_access_controller.sv
// self-checking bench for the eeprom access controller
`timescale 1ns/1ns
module test_eeprom_access_controller;
  import eea_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        rst         = 1'b1;
  logic        por         = 1'b1;
  logic        ce          = 1'b1;
  logic [5:0]  io_addr     = 6'h00;
  logic        io_we       = 1'b0;
  logic        io_re       = 1'b0;
  logic [7:0]  io_wdata    = 8'h00;
  logic        global_ie   = 1'b0;
  logic        sleep_pwrdn = 1'b0;
  logic [7:0]  io_rdata, arr_wdata, arr_rdata;
  logic [10:0] arr_addr;
  logic        cpu_halt, ready_irq, rc_tick, rc_osc_hold, arr_we, arr_prog;
  int          errors      = 0;
  int          cmp_count   = 0;
  int          ticks       = 0;

  always #10 clk_sys = ~clk_sys;
  always @(posedge rc_tick) if (arr_prog) ticks++;

  eea_access_ctrl #(.LARGE_ARRAY(1'b1), .WRITE_RC_TICKS(5)) u_eea_access_ctrl (
    .CLK_SYS(clk_sys), .RST(rst), .POR(por), .CE(ce),
    .IO_ADDR(io_addr), .IO_WE(io_we), .IO_RE(io_re), .IO_WDATA(io_wdata),
    .IO_RDATA(io_rdata), .CPU_HALT(cpu_halt), .GLOBAL_IE(global_ie),
    .SLEEP_PWRDN(sleep_pwrdn), .READY_IRQ(ready_irq), .RC_TICK(rc_tick),
    .RC_OSC_HOLD(rc_osc_hold), .ARR_ADDR(arr_addr), .ARR_WDATA(arr_wdata),
    .ARR_WE(arr_we), .ARR_PROG(arr_prog), .ARR_RDATA(arr_rdata));

  eea_array_model u_eea_array_model (
    .clk(clk_sys), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_we(arr_we),
    .arr_rdata(arr_rdata), .rc_tick(rc_tick));

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected control byte from the bit layout
  function automatic logic [7:0] exp_ctl(input logic rie, input logic unl, input logic busy);
    logic [7:0] v;
    v = 8'h00;
    v[EEA_BIT_RIE] = rie;
    v[EEA_BIT_UNLOCK] = unl;
    v[EEA_BIT_WRITE] = busy;
    return v;
  endfunction

  // expected address-high read-back: only the stored bits
  function automatic logic [7:0] exp_hi(input logic [7:0] wv);
    return 8'(wv[EEA_ADDR_HI_W-1:0]);
  endfunction

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_we <= 1'b1;
    @(posedge clk_sys);
    io_we <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge clk_sys);
    io_re <= 1'b0;
    @(posedge clk_sys);
    #1 d = io_rdata;
  endtask

  task automatic obs(output int h, output int w);
    h = 0;
    w = 0;
    repeat (8) begin
      #1;
      h += int'(cpu_halt);
      w += int'(arr_we);
      @(posedge clk_sys);
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 800; i++) begin
      @(posedge clk_sys);
      #1;
      if (arr_prog === 1'b0) return;
    end
    errors++;
    print_verdict();
  endtask

  // address and data before unlock, after the idle wait of the caller
  // no flash self-programming runs in this bench
  // interrupts held off across the unlock sequence
  task automatic start_wr(input logic [10:0] a, input logic [7:0] d);
    logic ie;
    ie = global_ie;
    wr(EEA_OFS_ADDR_LOW, a[7:0]);
    global_ie <= 1'b0;
    wr(EEA_OFS_ADDR_HIGH, {5'h00, a[10:8]});
    wr(EEA_OFS_DATA, d);
    wr(EEA_OFS_CONTROL, 8'h0C);
    ticks = 0;
    wr(EEA_OFS_CONTROL, 8'h0A);
    global_ie <= ie;
  endtask

  initial begin
    logic [7:0]  d, c;
    logic [10:0] a;
    int          h, w;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    por <= 1'b0;
    void'($urandom(96027));
    rd(EEA_OFS_CONTROL, d);
    check(d, exp_ctl(1'b0, 1'b0, 1'b0));
    rd(6'h3A, d);
    check(d, 8'h00);
    wr(EEA_OFS_ADDR_HIGH, 8'hFF);
    rd(EEA_OFS_ADDR_HIGH, d);
    check(d, exp_hi(8'hFF));
    wr(EEA_OFS_CONTROL, 8'hF8);
    rd(EEA_OFS_CONTROL, d);
    check(d, exp_ctl(1'b1, 1'b0, 1'b0));
    @(posedge clk_sys);
    global_ie <= 1'b1;
    #2 check(ready_irq, 1'b1);
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 11'h7FF : 11'($urandom);
      d = 8'($urandom);
      start_wr(a, d);
      obs(h, w);
      check(h, 2);
      check(w, 1);
      check(arr_addr, a);
      check(arr_wdata, d);
      rd(EEA_OFS_CONTROL, c);
      check(c, exp_ctl(1'b1, 1'b0, 1'b1));
      check(ready_irq, 1'b0);
      wait_idle();
      check(ticks >= 4 && ticks <= 5, 1);
      check(ready_irq, 1'b1);
      wr(EEA_OFS_DATA, ~d);
      wr(EEA_OFS_CONTROL, 8'h09);
      obs(h, w);
      check(h, 4);
      rd(EEA_OFS_DATA, c);
      check(c, d);
      rd(EEA_OFS_CONTROL, c);
      check(c, exp_ctl(1'b1, 1'b0, 1'b0));
    end
    // last cycle, first cycle past window, window frozen by clock enable
    for (int k = 2; k < 5; k++) begin
      wr(EEA_OFS_CONTROL, 8'h0C);
      ce <= (k != 4);
      repeat ((k == 4) ? 6 : k) @(posedge clk_sys);
      ce <= 1'b1;
      wr(EEA_OFS_CONTROL, 8'h0A);
      obs(h, w);
      check(w, k != 3);
      rd(EEA_OFS_CONTROL, c);
      check(c, exp_ctl(1'b1, 1'b0, k != 3));
      wait_idle();
    end
    wr(EEA_OFS_CONTROL, 8'h0A);
    obs(h, w);
    check(h + w, 0);
    global_ie <= 1'b0;
    #2 check(ready_irq, 1'b0);
    a = 11'($urandom);
    d = 8'($urandom);
    start_wr(a, d);
    wr(EEA_OFS_ADDR_LOW, ~a[7:0]);
    wr(EEA_OFS_CONTROL, 8'h09);
    obs(h, w);
    check(h, 0);
    check(arr_addr, a);
    sleep_pwrdn <= 1'b1;
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1 check(arr_prog, 1'b1);
    wait_idle();
    check(rc_osc_hold, 1'b1);
    @(posedge clk_sys);
    sleep_pwrdn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check(rc_osc_hold, 1'b0);
    // power-down entered only once the write has finished
    wait_idle();
    @(posedge clk_sys);
    sleep_pwrdn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check(rc_osc_hold, 1'b0);
    print_verdict();
  end
endmodule // test_eeprom_access_controller
